/* File: thl_trip_recorder.sv */
// Purpose: trip recorder with log, freeze and register bus
// Assumes: inputs synchronous to ref_clk, word-only bus
// Notes  : bus slave answers with no wait states
//
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ns
`include "thl_params.svh"
module thl_trip_recorder
    import thl_pkg::*;
#(
    parameter int DEPTH = `THL_DEPTH,  // log entries
    parameter int NQTY  = `THL_NQTY,   // monitored quantities
    parameter int QW    = `THL_QW      // bits per quantity
)
(
    input  wire logic                ref_clk,       // 25 MHz clock
    input  wire logic                reset_n,       // async reset, low
    input  wire logic                hsel,          // slave select
    input  wire logic [31:0]         haddr,         // byte address
    input  wire logic [1:0]          htrans,        // transfer type
    input  wire logic                hwrite,        // write when high
    input  wire logic [2:0]          hsize,         // transfer size
    input  wire logic [31:0]         hwdata,        // write data
    input  wire logic                hready,        // bus ready
    output      logic [31:0]         hrdata,        // read data
    output      logic                hreadyout,     // slave ready
    output      logic                hresp,         // always okay
    input  wire logic                tripEvt,       // trip pulse
    input  wire logic [7:0]          tripCode,      // numeric trip code
    input  wire logic                tripHasSub,    // sub-code valid
    input  wire logic [7:0]          tripSubCode,   // sub-code
    input  wire logic                tripClearEvt,  // trip reset pulse
    input  wire logic [15:0]         dateNow,       // current date
    input  wire logic [15:0]         timeNow,       // current time
    input  wire logic [NQTY*QW-1:0]  liveQty,       // live quantities
    output      logic [NQTY*QW-1:0]  heldQty,       // shown quantities
    output      logic                pwrStageEn,    // power stage enable
    output      logic                tripped,       // trip standing
    output      logic                irq            // interrupt, high
);
    // log index is four bits wide, quantities need whole bits
    if (DEPTH < 2 || DEPTH > 16 || NQTY < 1 || QW < 1)
    begin : g_chk
        $error("thl_trip_recorder: bad DEPTH, NQTY or QW");
    end

    // ************************************************
    // reset release
    // ************************************************

    logic [1:0] rstSync_r;  // release pipeline
    logic       rstN;       // synchronised reset

    // assert at once, release after two edges
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            rstSync_r <= 2'h0;
        else
            rstSync_r <= {rstSync_r[0], 1'b1};
    end

    assign rstN = rstSync_r[1];

    // ************************************************
    // declarations
    // ************************************************

    thl_top_st_t state_r;    // registered state
    thl_top_st_t state_nxt;  // next state

    thl_hist_if  hb ();      // log store link

    logic        addrAcc;    // address phase taken
    logic        rdIrq;      // read of event register
    logic        logClr;     // log clear write
    logic        frz;        // freeze quantities
    logic [2:0]  evt;        // event pulses
    logic [11:0] aLow;       // decoded address bits
    logic [31:0] rdVal;      // read mux value
    logic [4:0]  hitCode;    // code region hit
    logic [4:0]  hitSub;     // sub-code region hit
    logic [4:0]  hitDate;    // date region hit
    logic [4:0]  hitTime;    // time region hit

    // ************************************************
    // helpers
    // ************************************************

    // bit 4 set on a hit, low bits give the entry
    function automatic logic [4:0] regionIdx(
        input logic [11:0] a,
        input logic [11:0] base
    );
        regionIdx = 5'h00;
        if (a[11:6] == base[11:6] && 32'(a[5:2]) < DEPTH)
        begin
            regionIdx = {1'b1, a[5:2]};
        end
    endfunction

    // ************************************************
    // bus address phase
    // ************************************************

    // upper address bits are not decoded: the map aliases
    assign aLow    = haddr[11:0];
    assign addrAcc = hsel && htrans[1] && hready;
    assign rdIrq   = addrAcc && !hwrite && aLow == `THL_OFF_IRQ;

    assign hitCode = regionIdx(aLow, `THL_BASE_CODE);
    assign hitSub  = regionIdx(aLow, `THL_BASE_SUB);
    assign hitDate = regionIdx(aLow, `THL_BASE_DATE);
    assign hitTime = regionIdx(aLow, `THL_BASE_TIME);

    // ************************************************
    // read mux
    // ************************************************

    // unmapped addresses read zero
    always_comb
    begin
        rdVal = 32'h0000_0000;
        unique case (aLow)
            `THL_OFF_CTRL:
            begin
                rdVal = {24'h00_0000, state_r.ctrl};
            end
            `THL_OFF_STAT:
            begin
                rdVal = {29'h0, frz, pwrStageEn, state_r.tripped};
            end
            `THL_OFF_IRQ:
            begin
                rdVal = {29'h0, state_r.irqStat};
            end
            `THL_OFF_MASK:
            begin
                rdVal = {29'h0, state_r.irqMask};
            end
            default:
            begin
                // log regions share one read port
                if (hitCode[4])
                    rdVal = {24'h00_0000, hb.rdEntry.code};
                else if (hitSub[4])
                    rdVal = {24'h00_0000, hb.rdEntry.sub};
                else if (hitDate[4])
                    rdVal = {16'h0000, hb.rdEntry.date};
                else if (hitTime[4])
                    rdVal = {16'h0000, hb.rdEntry.tod};
            end
        endcase
    end

    // ************************************************
    // log store
    // ************************************************

    // clear accepted only from the register bus
    assign logClr = state_r.dpWr
                 && state_r.dpAddr == `THL_OFF_LOGCLR
                 && hwdata == `THL_CLR_KEY;

    assign hb.push          = tripEvt;
    assign hb.clear         = logClr;
    assign hb.subValid      = tripHasSub;
    // one whole-entry driver, fields in struct order
    assign hb.newEntry      = {tripCode, tripSubCode, dateNow, timeNow};
    assign hb.rdIdx         = aLow[5:2];

    thl_history #(
        .DEPTH   (DEPTH)
    ) u_hist (
        .ref_clk (ref_clk),
        .rstN    (rstN),
        .hb      (hb)
    );

    // ************************************************
    // freeze of monitored quantities
    // ************************************************

    // includes the trip cycle so pre-trip values are held
    assign frz = (state_r.tripped || tripEvt)
              && !state_r.ctrl[`THL_CTRL_NOFRZ];

    thl_freeze #(
        .NQTY    (NQTY),
        .QW      (QW)
    ) u_frz (
        .ref_clk (ref_clk),
        .rstN    (rstN),
        .freeze  (frz),
        .liveQty (liveQty),
        .heldQty (heldQty)
    );

    // ************************************************
    // state update
    // ************************************************

    assign evt = {logClr, tripClearEvt, tripEvt};

    always_comb
    begin
        state_nxt = state_r;

        // trip latch, a new trip beats a clear
        if (tripEvt)
            state_nxt.tripped = 1'b1;
        else if (tripClearEvt)
            state_nxt.tripped = 1'b0;

        // sticky events, set wins over read clear
        state_nxt.irqStat = (rdIrq ? 3'h0 : state_r.irqStat) | evt;

        // data phase of a write
        if (state_r.dpWr)
        begin
            unique case (state_r.dpAddr)
                `THL_OFF_CTRL:
                begin
                    state_nxt.ctrl = hwdata[7:0];
                end
                `THL_OFF_MASK:
                begin
                    state_nxt.irqMask = hwdata[2:0];
                end
                default:
                begin
                    // other writes ignored
                end
            endcase
        end

        // next address phase; sub-word writes dropped
        state_nxt.dpWr   = addrAcc && hwrite && hsize == `THL_HSIZE_WORD;
        state_nxt.dpAddr = aLow;

        // read data captured at address phase
        if (addrAcc && !hwrite)
        begin
            state_nxt.rdData = rdVal;
        end
    end

    always_ff @(posedge ref_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            state_r         <= '0;
            state_r.ctrl    <= `THL_CTRL_RST;
            state_r.irqMask <= `THL_MASK_RST;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // ************************************************
    // outputs
    // ************************************************

    // no wait states, only okay answers
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = state_r.rdData;

    // power stage dropped in the trip cycle itself
    assign pwrStageEn = !state_r.tripped && !tripEvt;
    assign tripped    = state_r.tripped;
    assign irq        = |(state_r.irqStat & state_r.irqMask);

    // ************************************************
    // checks
    // ************************************************

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstN);

    property p_pwr_off;
        tripEvt && !tripClearEvt |-> !pwrStageEn ##1 !pwrStageEn;
    endproperty
    a_pwr_off: assert property (p_pwr_off)
        else $error("power stage on during trip");

    property p_clr_key;
        state_r.dpWr && state_r.dpAddr == `THL_OFF_LOGCLR
            |-> hb.clear == (hwdata == `THL_CLR_KEY);
    endproperty
    a_clr_key: assert property (p_clr_key)
        else $error("log clear key not honoured");

    property p_clr_src;
        !(state_r.dpWr && state_r.dpAddr == `THL_OFF_LOGCLR) |-> !hb.clear;
    endproperty
    a_clr_src: assert property (p_clr_src)
        else $error("log cleared without bus write");

    property p_frz_on;
        tripEvt && !state_r.ctrl[`THL_CTRL_NOFRZ] && !state_r.dpWr |-> frz ##1 frz;
    endproperty
    a_frz_on: assert property (p_frz_on)
        else $error("trip did not freeze");

    property p_rd_code;
        addrAcc && !hwrite && hitCode[4]
            |=> hrdata == {24'h00_0000, $past(hb.rdEntry.code)};
    endproperty
    a_rd_code: assert property (p_rd_code)
        else $error("log read not numeric code");

    property p_irq_rc;
        rdIrq && evt == 3'h0 |=> state_r.irqStat == 3'h0;
    endproperty
    a_irq_rc: assert property (p_irq_rc)
        else $error("event register not cleared by read");

    property p_trip_hold;
        tripped && !tripClearEvt |=> tripped;
    endproperty
    a_trip_hold: assert property (p_trip_hold)
        else $error("trip dropped before clear");

    property p_trip_clr;
        tripClearEvt && !tripEvt |=> !tripped;
    endproperty
    a_trip_clr: assert property (p_trip_clr)
        else $error("trip not cleared");

    c_trip_cleared: cover property (tripEvt ##[1:20] tripClearEvt);
    c_log_clear:    cover property (hb.clear);
    c_trip_nofrz:   cover property (tripEvt && state_r.ctrl[`THL_CTRL_NOFRZ]);
    c_irq:          cover property (irq);
endmodule

/* File: thl_params.svh */
// Purpose: constants of the trip history recorder
// Assumes: 32-bit ahb-lite register bus, word access only
// Notes  : byte offsets, field bits, reset values and sizes
`ifndef THL_PARAMS_SVH
`define THL_PARAMS_SVH

// sizes
`define THL_DEPTH       10
`define THL_NQTY        20
`define THL_QW          16

// register byte offsets
`define THL_OFF_CTRL    12'h000
`define THL_OFF_LOGCLR  12'h004
`define THL_OFF_STAT    12'h008
`define THL_OFF_IRQ     12'h00c
`define THL_OFF_MASK    12'h010
`define THL_BASE_CODE   12'h040
`define THL_BASE_SUB    12'h080
`define THL_BASE_DATE   12'h0c0
`define THL_BASE_TIME   12'h100

// fields and values
`define THL_CTRL_NOFRZ  4
`define THL_CLR_KEY     32'h0000_00ff
`define THL_CTRL_RST    8'h00
`define THL_MASK_RST    3'h0
`define THL_IRQ_TRIP    0
`define THL_IRQ_TCLR    1
`define THL_IRQ_LCLR    2
`define THL_HSIZE_WORD  3'h2

`endif

/* File: thl_pkg.sv */
// Purpose: shared types of the trip history recorder
// Assumes: constants come from thl_params.svh
// Notes  : widths of one log entry are fixed here
package thl_pkg;
    `include "thl_params.svh"

    // one log entry: code, sub-code, date and time stamps
    typedef struct packed {
        logic [7:0]  code;
        logic [7:0]  sub;
        logic [15:0] date;
        logic [15:0] tod;
    } thl_entry_t;

    // whole state of the top module
    typedef struct packed {
        logic        tripped;  // trip active
        logic [7:0]  ctrl;     // trip behaviour control
        logic [2:0]  irqStat;  // sticky events
        logic [2:0]  irqMask;  // interrupt enables
        logic        dpWr;     // write data phase pending
        logic [11:0] dpAddr;   // address of that phase
        logic [31:0] rdData;   // read data for the bus
    } thl_top_st_t;
endpackage

/* File: thl_hist_if.sv */
// Purpose: link between control and the trip log store
// Assumes: one clock, driven by the control side
// Notes  : read port is combinational from the store
`timescale 1ns/1ns
interface thl_hist_if;
    import thl_pkg::*;
    logic       push;      // log one new trip
    logic       clear;     // wipe whole log
    logic       subValid;  // new trip carries a sub-code
    thl_entry_t newEntry;  // entry to log
    logic [3:0] rdIdx;     // entry to read
    thl_entry_t rdEntry;   // entry read back

    modport ctl (output push, clear, subValid, newEntry, rdIdx, input rdEntry);
    modport store (input push, clear, subValid, newEntry, rdIdx, output rdEntry);
endinterface

/* File: thl_history.sv */
// Purpose: shift log of the most recent trips with stamps
// Assumes: push and clear are one-cycle pulses
// Notes  : clear and push together leave only the new trip
`timescale 1ns/1ns
`include "thl_params.svh"
module thl_history
    import thl_pkg::*;
#(
    parameter int DEPTH = `THL_DEPTH  // entries kept
)
(
    input wire logic  ref_clk,  // clock
    input wire logic  rstN,     // synchronised reset, low
    thl_hist_if.store hb        // log port
);
    // ************************************************
    // state
    // ************************************************
    typedef struct packed {
        thl_entry_t [DEPTH-1:0] ent;  // entry 0 newest
    } thl_hist_st_t;

    thl_hist_st_t state_r;    // registered log
    thl_hist_st_t state_nxt;  // next log

    // shift needs two entries, index is four bits
    if (DEPTH < 2 || DEPTH > 16)
    begin : g_chk
        $error("thl_history: DEPTH must be 2..16");
    end

    // next log: wipe first, then shift in
    always_comb
    begin
        state_nxt = state_r;
        if (hb.clear)
        begin
            state_nxt.ent = '0;
        end
        if (hb.push)
        begin
            for (int i = DEPTH - 1; i > 0; i--)
            begin
                state_nxt.ent[i] = state_nxt.ent[i-1];
            end
            state_nxt.ent[0] = hb.newEntry;
            if (!hb.subValid)
            begin
                state_nxt.ent[0].sub = 8'h00;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstN)
    begin
        if (!rstN)
            state_r <= '0;
        else
            state_r <= state_nxt;
    end

    // out of range reads give zero
    assign hb.rdEntry = (32'(hb.rdIdx) < DEPTH) ? state_r.ent[hb.rdIdx] : '0;

    // ************************************************
    // checks
    // ************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstN);

    property p_newest;
        hb.push |=> state_r.ent[0].code == $past(hb.newEntry.code);
    endproperty
    a_newest: assert property (p_newest)
        else $error("newest code not in entry 0");

    property p_shift;
        hb.push && !hb.clear |=> state_r.ent[1] == $past(state_r.ent[0]);
    endproperty
    a_shift: assert property (p_shift)
        else $error("log did not shift");

    property p_stamp;
        hb.push |=> {state_r.ent[0].date, state_r.ent[0].tod}
            == $past({hb.newEntry.date, hb.newEntry.tod});
    endproperty
    a_stamp: assert property (p_stamp)
        else $error("stamps not logged");

    property p_subkeep;
        hb.push && hb.subValid |=> state_r.ent[0].sub == $past(hb.newEntry.sub);
    endproperty
    a_subkeep: assert property (p_subkeep)
        else $error("sub-code lost");

    property p_subzero;
        hb.push && !hb.subValid |=> state_r.ent[0].sub == 8'h00;
    endproperty
    a_subzero: assert property (p_subzero)
        else $error("missing sub-code not zero");

    property p_wipe;
        hb.clear && !hb.push |=> state_r == '0;
    endproperty
    a_wipe: assert property (p_wipe)
        else $error("log not wiped at once");
endmodule

/* File: thl_freeze.sv */
// Purpose: hold monitored quantities while a trip stands
// Assumes: freeze already includes the trip of this cycle
// Notes  : output is the value of the cycle before the trip
`timescale 1ns/1ns
`include "thl_params.svh"
module thl_freeze
    import thl_pkg::*;
#(
    parameter int NQTY = `THL_NQTY,  // quantities
    parameter int QW   = `THL_QW     // bits each
)
(
    input  wire logic                ref_clk,  // clock
    input  wire logic                rstN,     // synchronised reset, low
    input  wire logic                freeze,   // hold values
    input  wire logic [NQTY*QW-1:0]  liveQty,  // live values
    output      logic [NQTY*QW-1:0]  heldQty   // shown values
);
    if (NQTY < 1 || QW < 1 || QW > 32)
    begin : g_chk
        $error("thl_freeze: bad NQTY or QW");
    end

    typedef struct packed {
        logic [NQTY*QW-1:0] held;  // snapshot
    } thl_frz_st_t;

    thl_frz_st_t state_r;    // registered snapshot
    thl_frz_st_t state_nxt;  // next snapshot

    // follow live values unless frozen
    always_comb
    begin
        state_nxt = state_r;
        if (!freeze)
        begin
            state_nxt.held = liveQty;
        end
    end

    always_ff @(posedge ref_clk or negedge rstN)
    begin
        if (!rstN)
            state_r <= '0;
        else
            state_r <= state_nxt;
    end

    assign heldQty = state_r.held;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstN);

    property p_hold;
        freeze |=> heldQty == $past(heldQty);
    endproperty
    a_hold: assert property (p_hold)
        else $error("frozen value moved");

    property p_follow;
        !freeze |=> heldQty == $past(liveQty);
    endproperty
    a_follow: assert property (p_follow)
        else $error("value not updating");
endmodule

/* File: thl_ahb_host.sv */
// Purpose: serial host model, single-word ahb-lite master
// Assumes: one slave, its hreadyout is the bus hready
// Notes  : called by the bench through its xfer task
`timescale 1ns/1ns
module thl_ahb_host
(
    input  wire logic        ref_clk,  // bus clock
    input  wire logic        hready,   // bus ready
    input  wire logic [31:0] hrdata,   // read data
    output      logic        hsel,     // slave select
    output      logic [31:0] haddr,    // byte address
    output      logic [1:0]  htrans,   // transfer type
    output      logic        hwrite,   // write flag
    output      logic [2:0]  hsize,    // always a word
    output      logic [31:0] hwdata    // write data
);
    // idle bus at time zero
    initial
    begin
        hsel   = 1'b0;
        haddr  = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0;
    end

    // one transfer; waits on hready, never on a fixed count
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge ref_clk);
        hsel   <= 1'b1;
        haddr  <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge ref_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        // reads carry a changing pattern, never stale data
        hwdata <= w ? wd : ~hwdata;
        do @(posedge ref_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
endmodule

/* File: test_thl_trip_recorder.sv */
// Purpose: self-checking bench of the trip recorder
// Assumes: zero-wait bus slave, default sizes
// Notes  : one task per scenario
`timescale 1ns/1ns
`include "thl_params.svh"
module test_thl_trip_recorder;
    import thl_pkg::*;
    logic ref_clk = 1'b0, reset_n = 1'b0, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic tripEvt = 1'b0, tripHasSub = 1'b0, tripClearEvt = 1'b0;
    logic [7:0] tripCode = 8'h0, tripSubCode = 8'h0;
    logic [15:0] dateNow = 16'h0, timeNow = 16'h0;
    logic [319:0] liveQty = '0, heldQty;
    logic pwrStageEn, tripped, irq;
    int bad_count = 0, tests_run = 0;
    logic [11:0] bases [4] = '{`THL_BASE_CODE, `THL_BASE_SUB, `THL_BASE_DATE, `THL_BASE_TIME};

    // 40 ns period
    always #20 ref_clk = ~ref_clk;

    thl_ahb_host u_host (.ref_clk(ref_clk), .hready(hreadyout), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata));

    thl_trip_recorder u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .tripEvt(tripEvt),
        .tripCode(tripCode), .tripHasSub(tripHasSub), .tripSubCode(tripSubCode),
        .tripClearEvt(tripClearEvt), .dateNow(dateNow), .timeNow(timeNow),
        .liveQty(liveQty), .heldQty(heldQty), .pwrStageEn(pwrStageEn),
        .tripped(tripped), .irq(irq));

    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input string n, input logic [319:0] e, input logic [319:0] g);
        tests_run++;
        if (g !== e)
        begin
            bad_count++;
            $display("unexpected %s: expected %0h seen %0h", n, e, g);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        u_host.xfer(1'b1, a, d, x);
        #1;  // let the ending edge land
    endtask

    task automatic rdchk(input string n, input logic [11:0] a, input logic [31:0] e);
        logic [31:0] d;
        u_host.xfer(1'b0, a, 32'h0, d);
        chk(n, {288'h0, e}, {288'h0, d});
    endtask

    // one trip or clear pulse, live values changed as it ends
    task automatic pulse(input logic t, input logic [319:0] q);
        @(posedge ref_clk);
        tripEvt      <= t;
        tripClearEvt <= !t;
        tripCode     <= 8'h42;
        tripHasSub   <= 1'b0;
        @(posedge ref_clk);
        tripEvt      <= 1'b0;
        tripClearEvt <= 1'b0;
        liveQty      <= q;
        repeat (3) @(posedge ref_clk);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        rdchk("ctrl", `THL_OFF_CTRL, 32'h0);
        rdchk("mask", `THL_OFF_MASK, 32'h0);
        rdchk("unmapped", 12'h020, 32'h0);
        rdchk("stat", `THL_OFF_STAT, 32'h2);
        chk("pwr", 320'h1, {319'h0, pwrStageEn});
        chk("tripped", 320'h0, {319'h0, tripped});
        chk("hreadyout", 320'h1, {319'h0, hreadyout});
        chk("hresp", 320'h0, {319'h0, hresp});
    endtask

    // eleven back-to-back trips, oldest falls off
    task automatic t_log;
        logic [7:0] i;
        for (int n = 0; n < 11; n++)
        begin
            @(posedge ref_clk);
            tripEvt     <= 1'b1;
            tripCode    <= 8'h10 + n[7:0];
            tripHasSub  <= n[0];
            tripSubCode <= 8'h80 + n[7:0];
            dateNow     <= 16'h2000 + n[15:0];
            timeNow     <= 16'h3000 + n[15:0];
            #1 chk("pwr", 320'h0, {319'h0, pwrStageEn});
        end
        @(posedge ref_clk);
        tripEvt <= 1'b0;
        for (int k = 0; k < 10; k++)
        begin
            i = 8'h0a - k[7:0];
            rdchk("code", bases[0] + 12'(4 * k), 32'h10 + i);
            rdchk("sub", bases[1] + 12'(4 * k), i[0] ? 32'h80 + i : 32'h0);
            rdchk("date", bases[2] + 12'(4 * k), 32'h2000 + i);
            rdchk("time", bases[3] + 12'(4 * k), 32'h3000 + i);
        end
        rdchk("beyond", bases[0] + 12'h028, 32'h0);
        pulse(1'b0, liveQty);
    endtask

    task automatic t_freeze;
        pulse(1'b0, {20{16'haaaa}});
        pulse(1'b1, {20{16'h5555}});
        chk("held", {20{16'haaaa}}, heldQty);
        chk("pwr", 320'h0, {319'h0, pwrStageEn});
        chk("tripped", 320'h1, {319'h0, tripped});
        rdchk("stat", `THL_OFF_STAT, 32'h5);
        pulse(1'b0, liveQty);
        chk("held", {20{16'h5555}}, heldQty);
        chk("tripped", 320'h0, {319'h0, tripped});
        wr(`THL_OFF_CTRL, 32'h10);
        pulse(1'b1, {20{16'h1234}});
        chk("held", {20{16'h1234}}, heldQty);
        rdchk("stat", `THL_OFF_STAT, 32'h1);
        pulse(1'b0, liveQty);
        wr(`THL_OFF_CTRL, 32'h0);
    endtask

    // wrong key ignored, right key wipes, interrupt path
    task automatic t_clear_irq;
        rdchk("irq", `THL_OFF_IRQ, 32'h3);
        wr(`THL_OFF_LOGCLR, 32'hfe);
        rdchk("code0", bases[0], 32'h42);
        wr(`THL_OFF_LOGCLR, `THL_CLR_KEY);
        for (int k = 0; k < 10; k++)
            for (int r = 0; r < 4; r++)
                rdchk("wiped", bases[r] + 12'(4 * k), 32'h0);
        chk("irq", 320'h0, {319'h0, irq});
        wr(`THL_OFF_MASK, 32'h4);
        chk("irq", 320'h1, {319'h0, irq});
        rdchk("irq", `THL_OFF_IRQ, 32'h4);
        #1 chk("irq", 320'h0, {319'h0, irq});
    endtask

    // ****************************************
    // run control
    // ****************************************
    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // hang guard, far beyond the few hundred cycles needed
    initial
    begin
        #(40 * 20000);
        bad_count++;
        finish_test();
    end

    initial
    begin
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        t_reset();
        t_log();
        t_freeze();
        t_clear_irq();
        finish_test();
    end
endmodule
